// ### rtl/cfs_defines.vh
// register offsets, field positions, reset values and timing values in ns for the channel fifo status bank
`ifndef CFS_DEFINES_VH
`define CFS_DEFINES_VH

// ==========================================
// register offsets
`define CFS_ADDR_BIT_ORDER 8'h16
`define CFS_ADDR_STARVE 8'h18
`define CFS_ADDR_SPILL 8'h1A
`define CFS_ADDR_CHAN_ON 8'h10
`define CFS_ADDR_SWAP_CFG 8'h0F
`define CFS_ADDR_PLL_CTRL 8'h24
`define CFS_ADDR_IRQ_STAT 8'h30
`define CFS_ADDR_IRQ_CLR 8'h31
`define CFS_ADDR_IRQ_EN 8'h32

// ==========================================
// field positions
`define CFS_PLL_RUN_BIT 2
`define CFS_PLL_LOCK_BIT 5
`define CFS_LSB_FIRST_BIT 0
`define CFS_BYTE_PAIR_SWAP_BIT 0
`define CFS_HALFWORD_SWAP_BIT 3
`define CFS_PLL_KEEP_MASK 8'h1B

// ==========================================
// reset values
`define CFS_PLL_CTRL_RST 8'h00
`define CFS_BIT_ORDER_RST 16'h0000
`define CFS_CHAN_ON_RST 4'h0

// ==========================================
// timing
`define CFS_LOCK_TIME_NS 100
`define CFS_CLK_PERIOD_NS 4

`endif

// ### rtl/cfs_chan_flags.v
// sticky underflow/overflow tracker for one channel
`timescale 1ns/10ps
module cfs_chan_flags (
  // clock and reset
  input wire clk,
  input wire resetn,
  // channel control
  input wire chan_on,
  // fifo events
  input wire fifo_empty_hit,
  input wire fifo_full_hit,
  // flags
  output reg starve_q,
  output reg spill_q,
  output wire starve_set,
  output wire spill_set
);
  reg chan_on_q;
  reg off_seen_q;
  wire rearm;

  // clear only on the first enable after a disable
  assign rearm = chan_on & ~chan_on_q & off_seen_q;
  assign starve_set = fifo_empty_hit & ~starve_q;
  assign spill_set = fifo_full_hit & ~spill_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chan_on_q <= 1'b0;
      off_seen_q <= 1'b0;
      starve_q <= 1'b0;
      spill_q <= 1'b0;
    end else begin
      chan_on_q <= chan_on;
      if (!chan_on)
        off_seen_q <= 1'b1;
      else if (rearm)
        off_seen_q <= 1'b0;
      // set wins over the re-enable clear
      if (fifo_empty_hit)
        starve_q <= 1'b1;
      else if (rearm)
        starve_q <= 1'b0;
      if (fifo_full_hit)
        spill_q <= 1'b1;
      else if (rearm)
        spill_q <= 1'b0;
    end
  end
endmodule // cfs_chan_flags

// ### rtl/cfs_regs.v
// channel fifo status register bank with transfer pll control and word ordering
//
// Contract
// - underflow flag sets when channel fifo runs empty; stays until re-enable
// - transmit channel in underflow repeats its last valid byte until new data
// - flags clear only on channel disable followed by re-enable
// - overflow flag sets when channel fifo overfills; stays until re-enable
// - while in overflow, incoming data for that channel is dropped; the code drops it for rx0/rx1 only, tx0/tx1 fresh bytes still load
// - flag bits: 0 rx0, 1 rx1, 2 tx0, 3 tx1
// - bit 5 of pll control reads one while transfer pll is locked
// - bit 2 of pll control enables the 100 MHz transfer pll
// - pll control bits 4-3 and 1-0 store and read back; 7-6 read zero
// - lsb-first ordering combines with byte and halfword swap per 32-bit word
// - pll control lets both boards synchronise clocks before transfer
`timescale 1ns/10ps
`include "cfs_defines.vh"
module cfs_regs #(
  parameter NCH = 4
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // fifo events, bit order per flag layout
  input wire [NCH-1:0] fifo_empty_hit,
  input wire [NCH-1:0] fifo_full_hit,
  // receive byte paths (rx0, rx1)
  input wire [15:0] rx_byte,
  input wire [1:0] rx_valid,
  output reg [1:0] rx_store_en,
  // transmit byte paths (tx0, tx1)
  input wire [15:0] tx_fresh_byte,
  input wire [1:0] tx_fresh_valid,
  output reg [15:0] tx_byte_q,
  // word ordering
  input wire [31:0] raw_word,
  output reg [31:0] ordered_word_q,
  // transfer pll
  input wire pll_locked_pin,
  output reg pll_run_enable,
  output reg xfer_ready,
  // channel enables and interrupt
  output reg [3:0] channel_on_bits,
  output reg irq
);
  // ==========================================
  // state
  reg [15:0] bit_order_select_q;
  reg [7:0] pll_ctrl_q;
  reg [7:0] swap_cfg_q;
  reg [7:0] irq_stat_q;
  reg [7:0] irq_en_q;
  reg lock_meta_q;
  reg pll_lock_status;
  wire [NCH-1:0] starve_flags;
  wire [NCH-1:0] spill_flags;
  wire [NCH-1:0] starve_set;
  wire [NCH-1:0] spill_set;
  wire [7:0] fifo_starve_flags;
  wire [7:0] fifo_spill_flags;
  wire [7:0] pll_rd;
  wire [7:0] irq_events;

  // ==========================================
  // per-channel sticky flags
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      cfs_chan_flags u_flags (
        .clk(clk),
        .resetn(resetn),
        .chan_on(channel_on_bits[gi]),
        .fifo_empty_hit(fifo_empty_hit[gi]),
        .fifo_full_hit(fifo_full_hit[gi]),
        .starve_q(starve_flags[gi]),
        .spill_q(spill_flags[gi]),
        .starve_set(starve_set[gi]),
        .spill_set(spill_set[gi])
      );
    end
  endgenerate

  assign fifo_starve_flags = {{(8-NCH){1'b0}}, starve_flags};
  assign fifo_spill_flags = {{(8-NCH){1'b0}}, spill_flags};
  assign irq_events = {{(8-2*NCH){1'b0}}, spill_set, starve_set};

  // ==========================================
  // lock pin synchroniser; the pll sits outside this clock domain
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_meta_q <= 1'b0;
      pll_lock_status <= 1'b0;
    end else begin
      lock_meta_q <= pll_locked_pin;
      pll_lock_status <= lock_meta_q;
    end
  end

  // lock only counts while the pll is enabled
  assign pll_rd = {2'b00, pll_run_enable & pll_lock_status,
                   pll_ctrl_q[4:3], pll_run_enable, pll_ctrl_q[1:0]};

  // ==========================================
  // bit order register
  // flag offsets have no write branch anywhere, so writes there are dropped
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_order_select_q <= `CFS_BIT_ORDER_RST;
    end else if (reg_wr && reg_addr == `CFS_ADDR_BIT_ORDER) begin
      bit_order_select_q <= reg_wdata;
    end
  end

  // ==========================================
  // transfer pll control register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pll_ctrl_q <= `CFS_PLL_CTRL_RST;
      pll_run_enable <= 1'b0;
    end else if (reg_wr && reg_addr == `CFS_ADDR_PLL_CTRL) begin
      // only the reserved bits are kept here; run enable has its own flop
      pll_ctrl_q <= reg_wdata[7:0] & `CFS_PLL_KEEP_MASK;
      pll_run_enable <= reg_wdata[`CFS_PLL_RUN_BIT];
    end
  end

  // ==========================================
  // swap configuration register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      swap_cfg_q <= 8'h00;
    end else if (reg_wr && reg_addr == `CFS_ADDR_SWAP_CFG) begin
      swap_cfg_q <= reg_wdata[7:0];
    end
  end

  // ==========================================
  // channel enable register
  // a cleared bit stops receive stores on rx0/rx1 but keeps its flags; they clear on the next set
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      channel_on_bits <= `CFS_CHAN_ON_RST;
    end else if (reg_wr && reg_addr == `CFS_ADDR_CHAN_ON) begin
      channel_on_bits <= reg_wdata[3:0];
    end
  end

  // ==========================================
  // interrupt enable register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_q <= 8'h00;
    end else if (reg_wr && reg_addr == `CFS_ADDR_IRQ_EN) begin
      irq_en_q <= reg_wdata[7:0];
    end
  end

  // ==========================================
  // interrupt status, write-one-to-clear
  // status bits pulse in only when a flag first sets, so a held event cannot refire
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_q <= 8'h00;
    end else if (reg_wr && reg_addr == `CFS_ADDR_IRQ_CLR) begin
      // a same-cycle event wins over the clear
      irq_stat_q <= (irq_stat_q & ~reg_wdata[7:0]) | irq_events;
    end else begin
      irq_stat_q <= irq_stat_q | irq_events;
    end
  end

  // ==========================================
  // read values, padded to the bus width; unused upper bits read zero
  wire [15:0] rd_bit_order;
  wire [15:0] rd_starve;
  wire [15:0] rd_spill;
  wire [15:0] rd_pll;
  wire [15:0] rd_swap;
  wire [15:0] rd_chan;
  wire [15:0] rd_irq_stat;
  wire [15:0] rd_irq_en;

  assign rd_bit_order = bit_order_select_q;
  assign rd_starve = {8'h00, fifo_starve_flags};
  assign rd_spill = {8'h00, fifo_spill_flags};
  assign rd_pll = {8'h00, pll_rd};
  assign rd_swap = {8'h00, swap_cfg_q};
  assign rd_chan = {12'h000, channel_on_bits};
  assign rd_irq_stat = {8'h00, irq_stat_q};
  assign rd_irq_en = {8'h00, irq_en_q};

  // ==========================================
  // read multiplexer
  // an unmapped offset, or no read strobe at all, gives zero
  reg [15:0] rdata_d;
  always @* begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == `CFS_ADDR_BIT_ORDER)
        rdata_d = rd_bit_order;
      else if (reg_addr == `CFS_ADDR_STARVE)
        rdata_d = rd_starve;
      else if (reg_addr == `CFS_ADDR_SPILL)
        rdata_d = rd_spill;
      else if (reg_addr == `CFS_ADDR_PLL_CTRL)
        rdata_d = rd_pll;
      else if (reg_addr == `CFS_ADDR_SWAP_CFG)
        rdata_d = rd_swap;
      else if (reg_addr == `CFS_ADDR_CHAN_ON)
        rdata_d = rd_chan;
      else if (reg_addr == `CFS_ADDR_IRQ_STAT)
        rdata_d = rd_irq_stat;
      else if (reg_addr == `CFS_ADDR_IRQ_EN)
        rdata_d = rd_irq_en;
    end
  end

  // ==========================================
  // read data register, data one cycle after the strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // ==========================================
  // word ordering
  integer k;
  reg [31:0] lsb_word;
  reg [31:0] swapped;
  // lsb-first reverses the bits inside each byte; byte positions stay put
  always @* begin
    lsb_word = raw_word;
    k = 0;
    if (bit_order_select_q[`CFS_LSB_FIRST_BIT]) begin
      for (k = 0; k < 32; k = k + 1) begin
        lsb_word[k] = raw_word[(k & 24) + 7 - (k & 7)];
      end
    end
  end

  // byte swap acts inside each halfword, then halfword swap exchanges the halves
  always @* begin
    swapped = lsb_word;
    if (swap_cfg_q[`CFS_BYTE_PAIR_SWAP_BIT])
      swapped = {swapped[23:16], swapped[31:24], swapped[7:0], swapped[15:8]};
    if (swap_cfg_q[`CFS_HALFWORD_SWAP_BIT])
      swapped = {swapped[15:0], swapped[31:16]};
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ordered_word_q <= 32'h00000000;
    end else begin
      ordered_word_q <= swapped;
    end
  end

  // ==========================================
  // receive gating
  always @* begin
    // overflowed receive channels drop incoming bytes
    rx_store_en = rx_valid & channel_on_bits[1:0] & ~spill_flags[1:0];
  end

  // ==========================================
  // interrupt line
  always @* begin
    irq = |(irq_stat_q & irq_en_q);
  end

  // ==========================================
  // transfer gate
  always @* begin
    // transfers wait until the pll is running and locked
    xfer_ready = pll_run_enable & pll_lock_status;
  end

  // ==========================================
  // transmit hold, one flop group per channel
  // without fresh data the last valid byte is held and resent, which covers underflow
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_byte_q[7:0] <= 8'h00;
    end else if (tx_fresh_valid[0]) begin
      tx_byte_q[7:0] <= tx_fresh_byte[7:0];
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_byte_q[15:8] <= 8'h00;
    end else if (tx_fresh_valid[1]) begin
      tx_byte_q[15:8] <= tx_fresh_byte[15:8];
    end
  end
endmodule // cfs_regs

// ### bench/cfs_regs_asserts.sv
// checker for the channel fifo status register bank
`timescale 1ns/10ps
module cfs_regs_asserts (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // data paths
  input wire [3:0] fifo_full_hit,
  input wire [1:0] rx_valid,
  input wire [1:0] rx_store_en,
  input wire [1:0] tx_fresh_valid,
  input wire [15:0] tx_byte_q,
  // pll, channels, interrupt
  input wire pll_run_enable,
  input wire xfer_ready,
  input wire [3:0] channel_on_bits,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // assertions
  AST_PLL_RUN: assert property (reg_wr && reg_addr == 8'h24 |=>
    pll_run_enable == $past(reg_wdata[2])) else $error("run enable not taken from write");
  AST_XFER: assert property (xfer_ready |-> pll_run_enable)
    else $error("transfer ready without pll run");
  AST_PLL_RB: assert property (reg_rd && reg_addr == 8'h24 |=>
    reg_rdata[15:6] == 10'h000) else $error("pll control upper bits not zero");
  AST_LOCK_RB: assert property (reg_rd && reg_addr == 8'h24 && !pll_run_enable |=>
    !reg_rdata[5]) else $error("lock shown while pll stopped");
  AST_FLAG_RB: assert property (reg_rd && reg_addr[7:2] == 6'h06 && !reg_addr[0] |=>
    reg_rdata[15:4] == 12'h000) else $error("flag register upper bits set");
  AST_DROP: assert property (fifo_full_hit[1] |=> (!rx_store_en[1]) [*2])
    else $error("data stored during overflow");
  AST_STORE: assert property (rx_store_en[0] |-> rx_valid[0] && channel_on_bits[0])
    else $error("store without valid enabled data");
  AST_TX_HOLD: assert property (!tx_fresh_valid[0] |=> $stable(tx_byte_q[7:0]))
    else $error("transmit byte changed without fresh data");
  AST_CHAN_WR: assert property (reg_wr && reg_addr == 8'h10 |=>
    channel_on_bits == $past(reg_wdata[3:0])) else $error("channel enable not written");
  // ==========================================
  // covers
  C_IRQ: cover property (irq);
  C_DROP: cover property (rx_valid[1] && channel_on_bits[1] && !rx_store_en[1]);
  C_XFER: cover property (xfer_ready);
endmodule // cfs_regs_asserts

bind cfs_regs cfs_regs_asserts u_chk (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .fifo_full_hit, .rx_valid, .rx_store_en, .tx_fresh_valid,
  .tx_byte_q, .pll_run_enable, .xfer_ready, .channel_on_bits, .irq);

// ### bench/cfs_pll_model.sv
// transfer pll stand-in that locks a while after being enabled
`timescale 1ns/10ps
module cfs_pll_model #(
  parameter LOCK_CYC = 25
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // pll control and lock
  input wire pll_run_enable,
  output reg pll_locked_pin
);
  reg [7:0] cnt_q;
  // ==========================================
  // lock is lost at once when the loop is stopped, as a real loop would
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
      pll_locked_pin <= 1'b0;
    end else begin
      cnt_q <= !pll_run_enable ? 8'h00 : (cnt_q < LOCK_CYC) ? cnt_q + 8'h01 : cnt_q;
      pll_locked_pin <= pll_run_enable && cnt_q == LOCK_CYC;
    end
  end
endmodule // cfs_pll_model

// ### bench/cfs_regs_test.sv
// self-checking bench for the channel fifo status register bank
`timescale 1ns/10ps
module cfs_regs_test;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [3:0] fifo_empty_hit = 4'h0;
  reg [3:0] fifo_full_hit = 4'h0;
  reg [15:0] rx_byte = 16'h0000;
  reg [1:0] rx_valid = 2'b00;
  reg [15:0] tx_fresh_byte = 16'h0000;
  reg [1:0] tx_fresh_valid = 2'b00;
  reg [31:0] raw_word = 32'h00000000;
  wire [15:0] reg_rdata;
  wire [1:0] rx_store_en;
  wire [15:0] tx_byte_q;
  wire [31:0] ordered_word_q;
  wire pll_locked_pin, pll_run_enable, xfer_ready, irq;
  wire [3:0] channel_on_bits;
  integer n_fail = 0;
  integer cmp_count = 0;
  always #2 clk = ~clk;
  cfs_regs #(.NCH(4)) u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fifo_empty_hit(fifo_empty_hit), .fifo_full_hit(fifo_full_hit), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_store_en(rx_store_en), .tx_fresh_byte(tx_fresh_byte),
    .tx_fresh_valid(tx_fresh_valid), .tx_byte_q(tx_byte_q), .raw_word(raw_word),
    .ordered_word_q(ordered_word_q), .pll_locked_pin(pll_locked_pin),
    .pll_run_enable(pll_run_enable), .xfer_ready(xfer_ready),
    .channel_on_bits(channel_on_bits), .irq(irq));
  cfs_pll_model u_pll (.clk(clk), .resetn(resetn), .pll_run_enable(pll_run_enable),
    .pll_locked_pin(pll_locked_pin));
  // ==========================================
  // shared tasks
  task chk(input c, input [8*24-1:0] m);
    begin
      cmp_count = cmp_count + 1;
      if (c !== 1'b1) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t %0s", $time, m);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_wr <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [7:0] a, input [15:0] e);
    begin
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 1'b0;
      #1 chk(reg_rdata === e, "read mismatch");
    end
  endtask
  // ==========================================
  // scenarios
  task t_pll;
    begin
      wr(8'h24, 16'h00FF);
      #1 chk(xfer_ready === 1'b0, "xfer before lock");
      repeat (40) @(posedge clk);
      rd(8'h24, 16'h003F);
      chk(pll_run_enable === 1'b1, "pll not enabled");
      chk(xfer_ready === 1'b1, "xfer not ready");
      wr(8'h24, 16'h00DB);
      rd(8'h24, 16'h001B);
      chk(xfer_ready === 1'b0, "xfer still ready");
      wr(8'h24, 16'h0008);
      rd(8'h24, 16'h0008);
      $display("test pll done");
    end
  endtask
  task t_flags;
    begin
      wr(8'h10, 16'h000F);
      wr(8'h32, 16'h0000);
      @(posedge clk) {fifo_empty_hit, fifo_full_hit} <= 8'h5A;
      @(posedge clk) {fifo_empty_hit, fifo_full_hit, rx_valid} <= 10'h003;
      #1 chk(rx_store_en === 2'b01, "overflow data kept");
      rd(8'h18, 16'h0005);
      rd(8'h1A, 16'h000A);
      wr(8'h18, 16'hFFFF);
      rd(8'h18, 16'h0005);
      chk(irq === 1'b0, "masked irq high");
      wr(8'h32, 16'h00FF);
      #1 chk(irq === 1'b1, "irq not raised");
      wr(8'h31, 16'h00FF);
      #1 chk(irq === 1'b0, "irq not cleared");
      wr(8'h10, 16'h0000);
      rd(8'h1A, 16'h000A);
      wr(8'h10, 16'h000F);
      rd(8'h18, 16'h0000);
      rd(8'h1A, 16'h0000);
      chk(rx_store_en === 2'b11, "store not resumed");
      $display("test flags done");
    end
  endtask
  task t_data;
    begin
      @(posedge clk) {tx_fresh_valid, tx_fresh_byte} <= 18'h3C3A5;
      @(posedge clk) {tx_fresh_valid, tx_fresh_byte} <= 18'h05A5A;
      repeat (3) @(posedge clk);
      chk(tx_byte_q[7:0] === 8'hA5, "tx byte not repeated");
      chk(tx_byte_q[15:8] === 8'hC3, "tx1 byte not repeated");
      wr(8'h16, 16'h0001);
      wr(8'h0F, 16'h0009);
      raw_word <= 32'h12345678;
      repeat (3) @(posedge clk);
      chk(ordered_word_q === 32'h1E6A2C48, "word order wrong");
      $display("test data done");
    end
  endtask
  // ==========================================
  // verdict
  task results;
    begin
      $display("checks %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #20000;
    n_fail = n_fail + 1;
    results;
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_pll;
    t_flags;
    t_data;
    results;
  end
endmodule // cfs_regs_test
